/* File: design/thermal_pkg.sv */
/*
  Constants for the thermal throttle and clock modulation block:
  register addresses, field positions, reset values and timing counts.
  Assumes a 40 MHz core clock and a 64-bit model-specific register port.
*/
package thermal_pkg;
  // ==========================================================
  // Register addresses on the model-specific register port
  localparam logic [11:0] ADDR_STATUS  = 12'h000;
  localparam logic [11:0] ADDR_IRQCTL  = 12'h001;
  localparam logic [11:0] ADDR_CLKMOD  = 12'h002;
  localparam logic [11:0] ADDR_MISC    = 12'h003;
  localparam logic [11:0] ADDR_LVT     = 12'h004;

  // ==========================================================
  // Field positions
  localparam int ST_LIVE      = 0;
  localparam int ST_LOG       = 1;
  localparam int IRQ_HI_EN    = 0;
  localparam int IRQ_LO_EN    = 1;
  localparam int CM_DUTY_LO   = 1;
  localparam int CM_EN        = 4;
  localparam int MISC_THR     = 3;
  localparam int MISC_FV      = 13;
  localparam int MISC_ADAPT   = 16;
  localparam int LVT_VEC_LO   = 0;
  localparam int LVT_MODE_LO  = 8;
  localparam int LVT_MASK     = 16;

  // ==========================================================
  // Reset values and codes
  localparam logic [2:0] DUTY_RESERVED = 3'h0;
  localparam logic [2:0] DUTY_DEFAULT  = 3'h1;
  localparam logic [2:0] DUTY_MAX      = 3'h7;
  localparam logic [2:0] THROTTLE_DUTY = 3'h4;
  localparam logic [1:0] FV_FIRST      = 2'h1;
  localparam logic [1:0] FV_DEEPEST    = 2'h3;
  localparam logic [1:0] FV_NONE       = 2'h0;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 40;
  localparam int MIN_ENGAGE_NS    = 1000000;
  localparam int MIN_ENGAGE_CYC   = (MIN_ENGAGE_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOT_CYCLES      = 4;
  localparam logic [2:0] SLOT_LAST = 3'h7;
endpackage

/* File: design/duty_gate.sv */
/*
  Duty-cycle gate: a repeating window of eight clock-enable slots,
  running for the first N slots where N is the three-bit duty code.
  Assumes one clock; slot length comes from an internal divider.
*/
`timescale 1ns/1ps
module duty_gate (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       active_in,
  input  wire logic [2:0] code_in,
  // Gate results
  output logic            run_out,
  output logic            window_end_out
);
  typedef struct packed {
    logic [7:0] div;
    logic [2:0] slot;
    logic [2:0] code;
    logic       act;
    logic       run;
    logic       wend;
  } gate_s;

  gate_s state_reg;
  gate_s state_next;

  // ==========================================================
  // Slot sequencing
  always_comb begin
    state_next      = state_reg;
    state_next.wend = 1'b0;
    state_next.act  = active_in;
    if (!active_in) begin
      state_next.div  = 8'h00;
      state_next.slot = 3'h0;
      state_next.run  = 1'b1;  // Ungated core clock when idle
    end else begin
      // Code is taken on activation and at each wrap, so a new setting never
      // cuts a run slot short in mid-window; it lands within one window
      if (!state_reg.act) begin
        state_next.code = code_in;
      end
      if (state_reg.div == 8'(thermal_pkg::SLOT_CYCLES - 1)) begin
        state_next.div  = 8'h00;
        state_next.slot = state_reg.slot + 3'h1;
        state_next.wend = (state_reg.slot == thermal_pkg::SLOT_LAST);
        if (state_reg.slot == thermal_pkg::SLOT_LAST) begin
          state_next.code = code_in;
        end
      end else begin
        state_next.div = state_reg.div + 8'h01;
      end
      // Code N runs N slots of eight; slot compare is unsigned
      state_next.run = ({1'b0, state_next.slot} < {1'b0, state_next.code});
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '{div: 8'h00, slot: 3'h0, code: thermal_pkg::DUTY_DEFAULT,
                     act: 1'b0, run: 1'b1, wend: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign run_out        = state_reg.run;
  assign window_end_out = state_reg.wend;
endmodule

/* File: design/thermal_throttle_clock_modulation.sv */
/*
  Thermal throttling and on-demand clock modulation for one core with
  two logical processors: status, log, interrupt request, minimum
  engagement with hysteresis, adaptive targets and clock gating.
  Assumes synchronous sensor inputs and a single-cycle register port.
  The sensor comparator, its hysteresis margin and the sibling core's
  trip line are produced elsewhere; this block only reacts to them.
  Delivery of the thermal request is left to the local interrupt
  controller, which takes vector and mode from the ports beside it.
  The core clock enable is meant for the internal stop-clock gate.
*/
`timescale 1ns/1ps
module thermal_throttle_clock_modulation #(
  parameter int MIN_ENGAGE_CYCLES = thermal_pkg::MIN_ENGAGE_CYC
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // Thermal sensor, trip point fixed in silicon
  input  wire logic        sensor_trip_in,
  input  wire logic        sensor_below_hyst_in,
  input  wire logic        other_core_trip_in,
  // Register port
  input  wire logic        msr_wr_in,
  input  wire logic        msr_rd_in,
  input  wire logic [11:0] msr_addr_in,
  input  wire logic        msr_lp_in,
  input  wire logic [63:0] msr_wdata_in,
  output logic [63:0]      msr_rdata_out,
  output logic             msr_ack_out,
  // Interrupt path
  input  wire logic        ext_irq_in,
  output logic             core_irq_out,
  output logic             thermal_irq_req_out,
  output logic [7:0]       thermal_irq_vector_out,
  output logic [2:0]       thermal_irq_mode_out,
  // Core clock and operating point
  output logic             core_clk_en_out,
  output logic             tsc_inc_out,
  output logic             fv_lower_out,
  output logic [1:0]       fv_target_out,
  // Feature flags
  output logic             feature_thermal_regs_out,
  output logic             feature_duty_throttle_out
);
  typedef struct packed {
    // Register port answer
    logic [63:0]      rdata;
    logic             ack;
    // Sensor history and engagement
    logic             sensor_d;
    logic             engaged;
    logic [31:0]      timer;
    logic             log;
    // Software controls
    logic             hi_en;
    logic             lo_en;
    logic [1:0]       cm_en;
    logic [1:0][2:0]  cm_duty;
    logic             misc_thr;
    logic             misc_fv;
    logic             misc_adapt;
    logic [7:0]       lvt_vec;
    logic [2:0]       lvt_mode;
    logic             lvt_mask;
    // Interrupt path
    logic             irq_req;
    logic             pend;
    logic             core_irq;
    // Operating point and constant flags
    logic [1:0]       fv_target;
    logic             fv_lower;
    logic             tsc_inc;
    logic             feat_regs;
    logic             feat_thr;
  } thermal_s;

  thermal_s state_reg;
  thermal_s state_next;

  // Gate results
  logic       gate_run;
  logic       gate_wend;
  // Selected modulation source
  logic       mod_active;
  logic [2:0] mod_code;
  // Thermal conditions seen this cycle
  logic       live;
  logic       trip_any;
  logic       trip_event;
  logic       trip_rose;
  logic       trip_fell;
  // On-demand request from both logical processors
  logic [2:0] od_code;
  logic       od_active;

  // ==========================================================
  // Helpers
  // Reserved code 000B behaves as the 12.5% default
  function automatic logic [2:0] legal_duty(input logic [2:0] code);
    legal_duty = (code == thermal_pkg::DUTY_RESERVED) ? thermal_pkg::DUTY_DEFAULT : code;
  endfunction

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic [11:0] addr);
    wr_hit = msr_wr_in && (msr_addr_in == addr);
  endfunction

  // Raw sensor edges; the log and both interrupt enables share them
  function automatic logic rose_now(input logic cur, input logic prev);
    rose_now = cur && !prev;
  endfunction

  // ==========================================================
  // Modulation source selection
  always_comb begin
    od_code   = 3'h0;
    od_active = 1'b0;
    // Highest enabled code of the two processors wins
    for (int i = 0; i < 2; i++) begin
      if (state_reg.cm_en[i]) begin
        od_active = 1'b1;
        if (legal_duty(state_reg.cm_duty[i]) > od_code) begin
          od_code = legal_duty(state_reg.cm_duty[i]);
        end
      end
    end
    // Engaged with any method enabled is "live"; only the throttle method runs the thermal duty
    live       = state_reg.engaged && (state_reg.misc_thr || state_reg.misc_fv
                 || state_reg.misc_adapt);
    if (live && state_reg.misc_thr) begin
      mod_active = 1'b1;
      mod_code   = thermal_pkg::THROTTLE_DUTY;
    end else begin
      mod_active = od_active;
      mod_code   = od_code;
    end
    // Sibling trips count only under adaptive throttling; the trip point
    // itself arrives on a pin, so no register can move it
    trip_any   = sensor_trip_in || (state_reg.misc_adapt && other_core_trip_in);
    trip_event = trip_any && !state_reg.engaged;
    // Edges use the raw pin, not the live flag, so a trip is logged even
    // while no throttle method is enabled
    trip_rose  = rose_now(sensor_trip_in, state_reg.sensor_d);
    trip_fell  = rose_now(state_reg.sensor_d, sensor_trip_in);
  end

  // ==========================================================
  // Internal stop-clock gate; the external stop pin is not involved
  // The gate takes its code at window edges, so a source change lands
  // on the next window rather than cutting a slot short
  duty_gate u_gate (
    .clock_in       (clock_in),
    .rst_n_in       (rst_n_in),
    .active_in      (mod_active),
    .code_in        (mod_code),
    .run_out        (gate_run),
    .window_end_out (gate_wend)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_next          = state_reg;
    state_next.ack      = 1'b0;
    state_next.irq_req  = 1'b0;
    state_next.core_irq = 1'b0;
    state_next.sensor_d = sensor_trip_in;
    // Constant outputs are registered too, so every port leaves a flop
    state_next.tsc_inc  = 1'b1;
    state_next.feat_regs = 1'b1;
    state_next.feat_thr  = 1'b1;

    // Engagement with a minimum hold, then hysteresis release
    // Only a fresh trip or an adaptive step reloads the hold; an engaged one keeps counting
    if (trip_event) begin
      state_next.engaged = 1'b1;
      state_next.timer   = 32'(MIN_ENGAGE_CYCLES - 1);
      state_next.fv_target = thermal_pkg::FV_FIRST;
    end else if (state_reg.engaged) begin
      // Hold counter first; hysteresis is only looked at once it runs out
      if (state_reg.timer != 32'h0000_0000) begin
        state_next.timer = state_reg.timer - 32'h0000_0001;
      end else if (sensor_below_hyst_in && !trip_any) begin
        state_next.engaged = 1'b0;
      end else if (state_reg.misc_adapt) begin
        // Still hot after a full hold: go one operating point deeper
        if (state_reg.fv_target != thermal_pkg::FV_DEEPEST) begin
          state_next.fv_target = state_reg.fv_target + 2'h1;
        end
        state_next.timer = 32'(MIN_ENGAGE_CYCLES - 1);
      end
    end
    // Operating-point request follows engagement only when a frequency or
    // voltage method is on; otherwise the target is parked at none
    if (state_next.engaged && (state_reg.misc_fv || state_reg.misc_adapt)) begin
      state_next.fv_lower = 1'b1;
    end else begin
      state_next.fv_lower  = 1'b0;
      state_next.fv_target = thermal_pkg::FV_NONE;
    end

    // Temperature crossings raise an unmasked thermal request
    if (!state_reg.lvt_mask) begin
      if ((trip_rose && state_reg.hi_en)
          || (trip_fell && state_reg.lo_en)) begin
        state_next.irq_req = 1'b1;
      end
    end

    // Held interrupts are released once the clock is not stopped mid-window
    if (state_reg.pend && (!mod_active || gate_wend)) begin
      state_next.pend     = 1'b0;
      state_next.core_irq = 1'b1;
    end
    // An interrupt meeting a release in the same cycle waits one cycle while mod_active is low,
    // since the delivery line carries one pulse per cycle
    if (ext_irq_in) begin
      if (!mod_active && !state_next.core_irq) begin
        state_next.core_irq = 1'b1;
      end else begin
        state_next.pend = 1'b1;
      end
    end

    // Register writes; no register reaches the trip point
    // Unmapped writes fall through and change nothing
    if (wr_hit(thermal_pkg::ADDR_STATUS) && !msr_wdata_in[thermal_pkg::ST_LOG]) begin
      state_next.log = 1'b0;
    end
    // Set after the clear, so a trip in the clearing cycle is never lost
    if (trip_rose) begin
      state_next.log = 1'b1;
    end
    if (wr_hit(thermal_pkg::ADDR_IRQCTL)) begin
      state_next.hi_en = msr_wdata_in[thermal_pkg::IRQ_HI_EN];
      state_next.lo_en = msr_wdata_in[thermal_pkg::IRQ_LO_EN];
    end
    if (wr_hit(thermal_pkg::ADDR_CLKMOD)) begin
      state_next.cm_en[msr_lp_in]   = msr_wdata_in[thermal_pkg::CM_EN];
      state_next.cm_duty[msr_lp_in] = msr_wdata_in[thermal_pkg::CM_DUTY_LO +: 3];
    end
    if (wr_hit(thermal_pkg::ADDR_MISC)) begin
      state_next.misc_thr   = msr_wdata_in[thermal_pkg::MISC_THR];
      state_next.misc_fv    = msr_wdata_in[thermal_pkg::MISC_FV];
      state_next.misc_adapt = msr_wdata_in[thermal_pkg::MISC_ADAPT];
    end
    if (wr_hit(thermal_pkg::ADDR_LVT)) begin
      state_next.lvt_vec  = msr_wdata_in[thermal_pkg::LVT_VEC_LO +: 8];
      state_next.lvt_mode = msr_wdata_in[thermal_pkg::LVT_MODE_LO +: 3];
      state_next.lvt_mask = msr_wdata_in[thermal_pkg::LVT_MASK];
    end

    // Reads return the stored state; unmapped addresses read zero
    state_next.ack = msr_rd_in || msr_wr_in;
    if (msr_rd_in) begin
      state_next.rdata = 64'h0;
      case (msr_addr_in)
        thermal_pkg::ADDR_STATUS: begin
          state_next.rdata[thermal_pkg::ST_LIVE] = live;
          state_next.rdata[thermal_pkg::ST_LOG]  = state_reg.log;
        end
        thermal_pkg::ADDR_IRQCTL: begin
          state_next.rdata[thermal_pkg::IRQ_HI_EN] = state_reg.hi_en;
          state_next.rdata[thermal_pkg::IRQ_LO_EN] = state_reg.lo_en;
        end
        // Enable and duty are those of the processor named on the port
        thermal_pkg::ADDR_CLKMOD: begin
          state_next.rdata[thermal_pkg::CM_EN] = state_reg.cm_en[msr_lp_in];
          state_next.rdata[thermal_pkg::CM_DUTY_LO +: 3] = state_reg.cm_duty[msr_lp_in];
        end
        thermal_pkg::ADDR_MISC: begin
          state_next.rdata[thermal_pkg::MISC_THR]   = state_reg.misc_thr;
          state_next.rdata[thermal_pkg::MISC_FV]    = state_reg.misc_fv;
          state_next.rdata[thermal_pkg::MISC_ADAPT] = state_reg.misc_adapt;
        end
        thermal_pkg::ADDR_LVT: begin
          state_next.rdata[thermal_pkg::LVT_VEC_LO +: 8]  = state_reg.lvt_vec;
          state_next.rdata[thermal_pkg::LVT_MODE_LO +: 3] = state_reg.lvt_mode;
          state_next.rdata[thermal_pkg::LVT_MASK]         = state_reg.lvt_mask;
        end
        default: begin
          state_next.rdata = 64'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register; enables clear and the vector entry masks at reset
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Duty fields wake at the default code, the vector entry masked
      state_reg            <= '0;
      state_reg.cm_duty    <= {thermal_pkg::DUTY_DEFAULT, thermal_pkg::DUTY_DEFAULT};
      state_reg.lvt_mask   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  // Register port
  assign msr_rdata_out             = state_reg.rdata;
  assign msr_ack_out               = state_reg.ack;
  // Interrupt path
  assign core_irq_out              = state_reg.core_irq;
  assign thermal_irq_req_out       = state_reg.irq_req;
  assign thermal_irq_vector_out    = state_reg.lvt_vec;
  assign thermal_irq_mode_out      = state_reg.lvt_mode;
  // Clock gate and operating point
  assign core_clk_en_out           = gate_run;
  assign tsc_inc_out               = state_reg.tsc_inc;
  assign fv_lower_out              = state_reg.fv_lower;
  assign fv_target_out             = state_reg.fv_target;
  // Constant feature flags
  assign feature_thermal_regs_out  = state_reg.feat_regs;
  assign feature_duty_throttle_out = state_reg.feat_thr;
endmodule

/* File: tb/thermal_checker.sv */
/*
  Port-level checker for the thermal throttle and clock modulation block.
  Assumes it is bound into the top module; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module thermal_checker (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  // Watched ports
  input  wire logic sensor_trip_in,
  input  wire logic thermal_irq_req_out,
  input  wire logic core_irq_out,
  input  wire logic core_clk_en_out,
  input  wire logic tsc_inc_out,
  input  wire logic feature_thermal_regs_out,
  input  wire logic feature_duty_throttle_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Helper: length of the current clock stop, saturating
  logic [5:0] stop_reg;

  // Slot 0 always runs, so a stop can never exceed seven slots
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_reg <= 6'h00;
    end else if (core_clk_en_out) begin
      stop_reg <= 6'h00;
    end else if (stop_reg != 6'h3F) begin
      stop_reg <= stop_reg + 6'h01;
    end
  end

  // ==========================================================
  // Sequences and assertions
  sequence s_run_slot;
    core_clk_en_out [*4];
  endsequence

  a_tsc_every_cycle: assert property (1'b1 |=> tsc_inc_out)
    else $error("time stamp increment missed");
  a_flag_regs_set: assert property (1'b1 |=> feature_thermal_regs_out)
    else $error("register feature flag low");
  a_flag_duty_set: assert property (1'b1 |=> feature_duty_throttle_out)
    else $error("duty throttle feature flag low");
  a_irq_on_edge: assert property (thermal_irq_req_out |->
      ($past(sensor_trip_in) != $past(sensor_trip_in, 2)) ||
      ($past(sensor_trip_in, 2) != $past(sensor_trip_in, 3)))
    else $error("thermal request without sensor edge");
  a_irq_single_pulse: assert property (thermal_irq_req_out |=> !thermal_irq_req_out)
    else $error("thermal request longer than one cycle");
  a_stop_bounded: assert property (stop_reg <= 6'h1C)
    else $error("clock stop longer than seven slots");
  a_run_slot_whole: assert property ($rose(core_clk_en_out) |-> s_run_slot)
    else $error("run slot shorter than four cycles");
  a_irq_held_off: assert property (core_irq_out |-> core_clk_en_out)
    else $error("interrupt delivered while clock stopped");
  c_clock_stop: cover property ($fell(core_clk_en_out));
endmodule

bind thermal_throttle_clock_modulation thermal_checker i_thermal_checker (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .sensor_trip_in(sensor_trip_in),
  .thermal_irq_req_out(thermal_irq_req_out), .core_irq_out(core_irq_out),
  .core_clk_en_out(core_clk_en_out), .tsc_inc_out(tsc_inc_out),
  .feature_thermal_regs_out(feature_thermal_regs_out),
  .feature_duty_throttle_out(feature_duty_throttle_out)
);

/* File: tb/core_model.sv */
/*
  Core-side partner: counts clocked core cycles and delivered interrupts,
  and sources external interrupt pulses. Assumes the block's clock domain.
*/
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // From the block and the bench
  input  wire logic        clk_en_in,
  input  wire logic        core_irq_in,
  input  wire logic        fire_in,
  // To the block and the bench
  output logic             ext_irq_out,
  output logic [15:0]      run_cnt_out,
  output logic [15:0]      irq_cnt_out
);
  // Core advances only on enabled cycles; it has no stop pin to lean on
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_irq_out <= 1'b0;
      run_cnt_out <= 16'h0000;
      irq_cnt_out <= 16'h0000;
    end else begin
      ext_irq_out <= fire_in;
      run_cnt_out <= run_cnt_out + 16'(clk_en_in);
      irq_cnt_out <= irq_cnt_out + 16'(core_irq_in);
    end
  end
endmodule

/* File: tb/thermal_throttle_clock_modulation_test.sv */
/*
  Self-checking bench: register port tasks and scenario sequences.
  Assumes a short hold count and the core_model partner.
*/
`timescale 1ns/1ps
module thermal_throttle_clock_modulation_test;
  localparam int HOLD = 20;
  localparam logic [11:0] A_ST = thermal_pkg::ADDR_STATUS;
  localparam logic [11:0] A_IC = thermal_pkg::ADDR_IRQCTL;
  localparam logic [11:0] A_CM = thermal_pkg::ADDR_CLKMOD;
  localparam logic [11:0] A_MI = thermal_pkg::ADDR_MISC;
  localparam logic [11:0] A_LV = thermal_pkg::ADDR_LVT;
  // Bench signals
  logic        clock_in, rst_n_in, sensor_trip_in, sensor_below_hyst_in, other_core_trip_in;
  logic        msr_wr_in, msr_rd_in, msr_lp_in, msr_ack_out, fire, ext_irq, core_irq;
  logic [11:0] msr_addr_in;
  logic [63:0] msr_wdata_in, msr_rdata_out;
  logic        irq_req, clk_en, fv_lower, feat_regs, feat_duty;
  logic [7:0]  vector;
  logic [2:0]  mode;
  logic [1:0]  fv_target;
  logic [15:0] run_cnt, irq_cnt, base;
  int          errors, n_compared;

  thermal_throttle_clock_modulation #(.MIN_ENGAGE_CYCLES(HOLD)) i_thermal_throttle_clock_modulation (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .sensor_trip_in(sensor_trip_in),
    .sensor_below_hyst_in(sensor_below_hyst_in), .other_core_trip_in(other_core_trip_in),
    .msr_wr_in(msr_wr_in), .msr_rd_in(msr_rd_in), .msr_addr_in(msr_addr_in),
    .msr_lp_in(msr_lp_in), .msr_wdata_in(msr_wdata_in), .msr_rdata_out(msr_rdata_out),
    .msr_ack_out(msr_ack_out), .ext_irq_in(ext_irq), .core_irq_out(core_irq),
    .thermal_irq_req_out(irq_req), .thermal_irq_vector_out(vector),
    .thermal_irq_mode_out(mode), .core_clk_en_out(clk_en), .tsc_inc_out(),
    .fv_lower_out(fv_lower), .fv_target_out(fv_target),
    .feature_thermal_regs_out(feat_regs), .feature_duty_throttle_out(feat_duty));
  core_model i_core_model (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
    .core_irq_in(core_irq), .fire_in(fire), .ext_irq_out(ext_irq),
    .run_cnt_out(run_cnt), .irq_cnt_out(irq_cnt));

  // 40 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Land just after the edge so inputs never race the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // One access per task; the idle cycle keeps strobes from being re-raised in one step
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    msr_wr_in = 1'b1;
    msr_addr_in = a;
    msr_wdata_in = d;
    cyc(1);
    chk(64'(msr_ack_out), 64'h1);
    msr_wr_in = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [63:0] m, input logic [63:0] e);
    msr_rd_in = 1'b1;
    msr_addr_in = a;
    cyc(1);
    chk(msr_rdata_out & m, e);
    msr_rd_in = 1'b0;
    cyc(1);
  endtask
  // Enabled cycles over one whole 32-cycle window, independent of phase
  task automatic runs(input logic [15:0] e);
    base = run_cnt;
    cyc(32);
    chk(64'(run_cnt - base), 64'(e));
  endtask
  task automatic req_seen(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      cyc(1);
      seen = seen | irq_req;
    end
    chk(64'(seen), 64'(e));
  endtask
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Stall guard
  initial begin
    #2000000;
    $display("BAD %0t run stalled", $time);
    errors++;
    print_verdict;
  end

  // Main sequence
  initial begin
    {rst_n_in, sensor_trip_in, sensor_below_hyst_in, other_core_trip_in} = 4'h0;
    {msr_wr_in, msr_rd_in, msr_lp_in, fire} = 4'h0;
    msr_addr_in = 12'h000;
    msr_wdata_in = 64'h0;
    errors = 0;
    n_compared = 0;
    cyc(3);
    rst_n_in = 1'b1;
    cyc(1);
    rd(A_IC, 64'h3, 64'h0);
    rd(A_LV, 64'h10000, 64'h10000);
    rd(A_CM, 64'h1E, 64'h2);
    rd(A_MI, 64'h8, 64'h0);
    rd(12'hFFF, 64'hFFFFFFFFFFFFFFFF, 64'h0);
    chk(64'({feat_regs, feat_duty}), 64'h3);
    wr(A_ST, 64'hFFFFFFFFFFFFFFFF);
    rd(A_ST, 64'h3, 64'h0);
    $display("Test reset done");
    wr(A_MI, 64'h8);
    wr(A_IC, 64'h3);
    wr(A_LV, 64'h25A);
    wr(A_CM, 64'h12);
    sensor_trip_in = 1'b1;
    req_seen(1'b1);
    chk(64'({vector, mode}), 64'h2D2);
    rd(A_ST, 64'h3, 64'h3);
    cyc(40);
    runs(16'h0010);
    sensor_trip_in = 1'b0;
    req_seen(1'b1);
    cyc(30);
    rd(A_ST, 64'h1, 64'h1);
    sensor_below_hyst_in = 1'b1;
    cyc(5);
    rd(A_ST, 64'h3, 64'h2);
    wr(A_ST, 64'h0);
    rd(A_ST, 64'h3, 64'h0);
    sensor_trip_in = 1'b1;
    cyc(2);
    sensor_trip_in = 1'b0;
    cyc(8);
    rd(A_ST, 64'h1, 64'h1);
    cyc(HOLD + 5);
    rd(A_ST, 64'h1, 64'h0);
    wr(A_LV, 64'h1025A);
    sensor_trip_in = 1'b1;
    wr(A_ST, 64'h0);
    rd(A_ST, 64'h2, 64'h2);
    sensor_trip_in = 1'b0;
    req_seen(1'b0);
    cyc(30);
    $display("Test thermal done");
    for (int c = 0; c < 8; c++) begin
      wr(A_CM, 64'(16 + 2 * c));
      cyc(40);
      runs(16'(c == 0 ? 4 : 4 * c));
    end
    msr_lp_in = 1'b1;
    wr(A_CM, 64'h1C);
    msr_lp_in = 1'b0;
    wr(A_CM, 64'h14);
    cyc(40);
    runs(16'h0018);
    msr_lp_in = 1'b1;
    rd(A_CM, 64'h1E, 64'h1C);
    wr(A_CM, 64'h06);
    msr_lp_in = 1'b0;
    wr(A_CM, 64'h06);
    cyc(8);
    runs(16'h0020);
    $display("Test duty done");
    wr(A_CM, 64'h12);
    cyc(40);
    base = irq_cnt;
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
    cyc(40);
    chk(64'(irq_cnt - base), 64'h1);
    $display("Test holdoff done");
    wr(A_MI, 64'h12000);
    other_core_trip_in = 1'b1;
    cyc(3);
    chk(64'({fv_lower, fv_target}), 64'h5);
    cyc(HOLD + 5);
    chk(64'(fv_target), 64'h2);
    other_core_trip_in = 1'b0;
    cyc(40);
    chk(64'(fv_lower), 64'h0);
    $display("Test adaptive done");
    print_verdict;
  end
endmodule
